// ===== rtl/bgcs_pkg.sv
package bgcs_pkg;

  localparam logic [3:0] BGCS_REG_CTRL    = 4'h0;
  localparam logic [3:0] BGCS_REG_SLEEP   = 4'h1;
  localparam logic [3:0] BGCS_REG_WAKE    = 4'h2;
  localparam logic [3:0] BGCS_REG_STATUS  = 4'h3;
  localparam logic [3:0] BGCS_REG_TRIM    = 4'h4;
  localparam logic [3:0] BGCS_REG_CALTIME = 4'h5;

  localparam int BGCS_CTRL_BG_EN     = 0;
  localparam int BGCS_CTRL_TRIG_SEL  = 1;
  localparam int BGCS_CTRL_SOFT_TRIG = 2;
  localparam int BGCS_CTRL_LOW_POWER_BG_ENABLE     = 3;
  localparam int BGCS_CTRL_LP_MAN    = 4;
  localparam int BGCS_CTRL_FG_OS     = 5;
  localparam int BGCS_CTRL_BG_OS     = 6;
  localparam int BGCS_CTRL_STAT_SEL  = 7;
  localparam int BGCS_CTRL_CAL_EN    = 8;

  localparam logic [31:0] BGCS_CTRL_RESET    = 32'h0000_0000;
  localparam logic [15:0] BGCS_SLEEP_RESET   = 16'h0100;
  localparam logic [15:0] BGCS_WAKE_RESET    = 16'h0010;
  localparam logic [15:0] BGCS_CALTIME_RESET = 16'h0040;
  localparam logic [1:0]  BGCS_STATSEL_HALT  = 2'h1;
  localparam int          BGCS_NUM_CORES     = 3;
  localparam int          BGCS_FG_OS_CYCLES  = 16;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bgcs_bus_req_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] active_a;
    logic [1:0] active_b;
  } bgcs_core_map_t;

endpackage : bgcs_pkg

// ===== rtl/bgcs_sequencer.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bgcs_sequencer
#(
  parameter int TRIM_W = 8
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire bgcs_pkg::bgcs_bus_req_t bus_i,
  output logic [31:0]                rdata_o,
  input  wire logic                  calib_trigger_pin_i,
  input  wire logic                  sample_strobe_i,
  input  wire logic                  core_cal_done_i,
  input  wire logic [TRIM_W-1:0]     offset_result_i,
  output logic                       calib_status_pin_o,
  output bgcs_pkg::bgcs_core_map_t   core_map_o,
  output logic                       spare_power_o,
  output logic                       core_cal_run_o,
  output logic                       offset_cal_run_o,
  output logic                       fg_cal_run_o,
  output logic                       swap_pulse_o
);
  import bgcs_pkg::*;

  typedef enum logic [2:0] {
    BGCS_IDLE, BGCS_FG, BGCS_SLEEP, BGCS_WAKE, BGCS_CAL, BGCS_HALT, BGCS_SWAP
  } bgcs_state_t;

  bgcs_state_t        state_r;
  logic [31:0]        ctrl_r;
  logic [15:0]        sleep_dly_r;
  logic [15:0]        wake_dly_r;
  logic [15:0]        cnt_r;
  logic [TRIM_W-1:0]  trim_r [BGCS_NUM_CORES];
  logic [1:0]         cal_core_r;
  logic               foreground_finished_flag_r;
  logic               halted_r;
  logic               fg_os_done_r;
  logic               trig_s1_r;
  logic               trig_s2_r;
  logic               trig_prev_r;
  logic [1:0]         statsel_r;
  bgcs_core_map_t     map_r;
  logic               cal_trigger;
  logic               low_power_bg_enable;
  logic               lp_manual;
  logic               bg_en;

  function automatic logic [1:0] bgcs_next_core(input logic [1:0] c);
    return (c == 2'h2) ? 2'h0 : c + 2'h1;
  endfunction : bgcs_next_core

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= calib_trigger_pin_i;
      trig_s2_r <= trig_s1_r;
    end
  end

  // Trigger selection: pin when the source bit is set, software bit otherwise.
  assign cal_trigger = ctrl_r[BGCS_CTRL_TRIG_SEL] ? trig_s2_r : ctrl_r[BGCS_CTRL_SOFT_TRIG];
  assign bg_en       = ctrl_r[BGCS_CTRL_BG_EN];
  assign low_power_bg_enable       = ctrl_r[BGCS_CTRL_LOW_POWER_BG_ENABLE];
  assign lp_manual   = ctrl_r[BGCS_CTRL_LP_MAN];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ctrl_r      <= BGCS_CTRL_RESET;
      sleep_dly_r <= BGCS_SLEEP_RESET;
      wake_dly_r  <= BGCS_WAKE_RESET;
      statsel_r   <= 2'h0;
    end else if (bus_i.wr) begin
      unique case (bus_i.addr)
        BGCS_REG_CTRL:   ctrl_r      <= bus_i.wdata;
        BGCS_REG_SLEEP:  sleep_dly_r <= bus_i.wdata[15:0];
        BGCS_REG_WAKE:   wake_dly_r  <= bus_i.wdata[15:0];
        BGCS_REG_STATUS: statsel_r   <= bus_i.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered, so it stands only in the cycle after the strobe.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        BGCS_REG_CTRL:   rdata_o <= ctrl_r;
        BGCS_REG_SLEEP:  rdata_o <= {16'h0000, sleep_dly_r};
        BGCS_REG_WAKE:   rdata_o <= {16'h0000, wake_dly_r};
        BGCS_REG_STATUS: rdata_o <= {24'h0000_00, 1'b0, state_r, foreground_finished_flag_r, halted_r,
                                     statsel_r};
        // Trim results are only meaningful after the foreground pass ends.
        BGCS_REG_TRIM:   rdata_o <= {8'h00, 8'(trim_r[2]), 8'(trim_r[1]), 8'(trim_r[0])};
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Sequencer. Trim writes from the bus are ignored; only calibration owns the trims.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_r      <= BGCS_IDLE;
      cnt_r        <= 16'h0000;
      cal_core_r   <= 2'h2;
      foreground_finished_flag_r    <= 1'b0;
      halted_r     <= 1'b0;
      fg_os_done_r <= 1'b0;
      trig_prev_r  <= 1'b0;
    end else begin
      trig_prev_r <= cal_trigger;
      unique case (state_r)
        BGCS_IDLE: begin
          // Foreground pass starts on a rising edge of the selected trigger.
          if (ctrl_r[BGCS_CTRL_CAL_EN] && cal_trigger && !trig_prev_r) begin
            state_r   <= BGCS_FG;
            cnt_r     <= 16'(BGCS_FG_OS_CYCLES);
            foreground_finished_flag_r <= 1'b0;
            // Every new pass repeats its one-time offset step.
            fg_os_done_r <= 1'b0;
          end
        end
        BGCS_FG: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            foreground_finished_flag_r    <= 1'b1;
            fg_os_done_r <= ctrl_r[BGCS_CTRL_FG_OS];
            if (bg_en) begin
              state_r <= low_power_bg_enable ? BGCS_SLEEP : BGCS_WAKE;
              cnt_r   <= low_power_bg_enable ? sleep_dly_r : wake_dly_r;
            end else begin
              state_r <= BGCS_IDLE;
            end
          end
        end
        BGCS_SLEEP: begin
          if (!bg_en) begin
            state_r <= BGCS_IDLE;
          end else if (lp_manual) begin
            if (!cal_trigger) begin
              state_r <= BGCS_WAKE;
              cnt_r   <= wake_dly_r;
            end
          end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            state_r <= BGCS_WAKE;
            cnt_r   <= wake_dly_r;
          end
        end
        BGCS_WAKE: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            state_r <= BGCS_CAL;
          end
        end
        BGCS_CAL: begin
          if (core_cal_done_i) begin
            halted_r <= 1'b1;
            state_r  <= BGCS_HALT;
          end
        end
        BGCS_HALT: begin
          // Manual mode waits for the trigger to return high before swapping.
          if (!(low_power_bg_enable && lp_manual) || cal_trigger) begin
            state_r <= BGCS_SWAP;
          end
        end
        BGCS_SWAP: begin
          if (sample_strobe_i) begin
            halted_r   <= 1'b0;
            cal_core_r <= bgcs_next_core(cal_core_r);
            state_r    <= low_power_bg_enable ? BGCS_SLEEP : BGCS_WAKE;
            cnt_r      <= low_power_bg_enable ? sleep_dly_r : 16'h0000;
          end
        end
        default: state_r <= BGCS_IDLE;
      endcase
    end
  end

  // Offset trims: cores 0 and 1 are captured during the foreground pass when requested, core 2 only with bg_en set,
  // and the core under calibration keeps updating in background offset mode.
  genvar gi;
  generate
    for (gi = 0; gi < BGCS_NUM_CORES; gi++) begin : g_trim
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          trim_r[gi] <= '0;
        end else if (state_r == BGCS_FG && cnt_r == 16'h0000 && ctrl_r[BGCS_CTRL_FG_OS]
                     && (gi < 2 || bg_en)) begin
          trim_r[gi] <= offset_result_i;
        end else if (state_r == BGCS_CAL && core_cal_done_i && ctrl_r[BGCS_CTRL_BG_OS]
                     && cal_core_r == 2'(gi)) begin
          trim_r[gi] <= offset_result_i;
        end
      end
    end
  endgenerate

  // Map rotation: the core just calibrated replaces the next active one.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      map_r <= '{spare: 2'h2, active_a: 2'h0, active_b: 2'h1};
    end else if (state_r == BGCS_SWAP && sample_strobe_i) begin
      map_r.spare    <= map_r.active_a;
      map_r.active_a <= map_r.active_b;
      map_r.active_b <= map_r.spare;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      swap_pulse_o <= 1'b0;
    end else begin
      swap_pulse_o <= (state_r == BGCS_SWAP) && sample_strobe_i;
    end
  end

  assign core_map_o         = map_r;
  assign calib_status_pin_o = (statsel_r == BGCS_STATSEL_HALT) && halted_r;
  assign spare_power_o      = !(low_power_bg_enable && (state_r == BGCS_SLEEP || state_r == BGCS_IDLE));
  assign core_cal_run_o     = (state_r == BGCS_CAL);
  assign fg_cal_run_o       = (state_r == BGCS_FG);
  assign offset_cal_run_o   = (state_r == BGCS_FG && ctrl_r[BGCS_CTRL_FG_OS] && !fg_os_done_r)
                              || (state_r == BGCS_CAL && ctrl_r[BGCS_CTRL_BG_OS]);

  // A spare core in manual mode must stay asleep while the trigger is high.
  a_manual_sleep_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_SLEEP && bg_en && low_power_bg_enable && lp_manual && cal_trigger) |=> state_r == BGCS_SLEEP)
    else $error("spare woke while trigger high");

  a_manual_wake_go: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_SLEEP && bg_en && lp_manual && !cal_trigger) |=> state_r == BGCS_WAKE)
    else $error("trigger low did not wake spare");

  a_manual_swap_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_HALT && low_power_bg_enable && lp_manual && !cal_trigger) |=> state_r == BGCS_HALT)
    else $error("swap before trigger high");

  sequence s_auto_cal_end;
    state_r == BGCS_CAL && core_cal_done_i && !lp_manual;
  endsequence
  sequence s_halt_then_swap;
    state_r == BGCS_HALT ##1 state_r == BGCS_SWAP;
  endsequence
  a_auto_swap_now: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_auto_cal_end |=> s_halt_then_swap)
    else $error("automatic swap delayed");

  a_swap_boundary: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    swap_pulse_o |-> $past(sample_strobe_i) && $past(state_r) == BGCS_SWAP)
    else $error("swap off sample boundary");

  a_status_pin: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (statsel_r == BGCS_STATSEL_HALT && state_r == BGCS_HALT) |-> calib_status_pin_o)
    else $error("halted flag not on status pin");

  a_lp_sleep_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_SLEEP && low_power_bg_enable) |-> !spare_power_o)
    else $error("spare powered while sleeping");

  a_wake_delay: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_WAKE && cnt_r != 16'h0000) |=> state_r == BGCS_WAKE)
    else $error("calibration started before wake delay");

  a_map_distinct: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    map_r.spare != map_r.active_a && map_r.spare != map_r.active_b
    && map_r.active_a != map_r.active_b)
    else $error("core map not a permutation");

  a_fg_start: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_IDLE && ctrl_r[BGCS_CTRL_CAL_EN] && cal_trigger && !trig_prev_r)
    |=> fg_cal_run_o)
    else $error("foreground pass did not start on trigger");

  a_auto_sleep_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_SLEEP && bg_en && !lp_manual && cnt_r != 16'h0000) |=> state_r == BGCS_SLEEP)
    else $error("spare woke before sleep delay");

  // The core under calibration must always be the spare of the map, or a live core is disturbed.
  a_cal_core_spare: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cal_core_r == map_r.spare)
    else $error("calibrated core is not the spare");

  // The halted indication must last exactly from calibration end to the swap.
  a_halt_flag: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    halted_r == (state_r == BGCS_HALT || state_r == BGCS_SWAP))
    else $error("halted flag out of step with sequencer");

  a_manual_halt_swap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_HALT && low_power_bg_enable && lp_manual && cal_trigger) |=> state_r == BGCS_SWAP)
    else $error("manual swap not taken with trigger high");

  a_spare_up: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state_r == BGCS_WAKE || state_r == BGCS_CAL) |-> spare_power_o)
    else $error("spare unpowered while waking or calibrating");

  // The last foreground cycle raises done and, with the foreground offset bit set, captures the trims of cores 0 and 1, and of core 2 only with bg_en set.
  sequence s_fg_last;
    state_r == BGCS_FG && cnt_r == 16'h0000;
  endsequence
  a_foreground_finished_flag_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_fg_last |=> foreground_finished_flag_r)
    else $error("foreground done flag not raised");

  a_trim_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_fg_last ##0 (ctrl_r[BGCS_CTRL_FG_OS] && bg_en))
    |=> trim_r[2] == $past(offset_result_i))
    else $error("spare trim not captured in foreground pass");

  // A second pulse in a row would mean a double rotation and a dropped core.
  a_swap_once: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    swap_pulse_o |=> !swap_pulse_o)
    else $error("swap repeated on consecutive cycles");

endmodule : bgcs_sequencer
`default_nettype wire

// ===== bench/bgcs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module bgcs_sequencer_test;
  import bgcs_pkg::*;
  localparam logic [31:0] AUTO = 32'h0000_0169;
  localparam logic [31:0] MAN  = 32'h0000_013B;
  logic           clock_i;
  logic           rst_b_i;
  logic           pin;
  logic           strobe;
  logic           strobe_en;
  logic           done;
  logic [7:0]     ofs;
  bgcs_bus_req_t  bus;
  logic [31:0]    rdata;
  logic           stat;
  logic           spwr;
  logic           crun;
  logic           orun;
  logic           frun;
  logic           swp;
  bgcs_core_map_t map;
  int             failures;
  int             comparisons;
  int             n;

  bgcs_sequencer bgcs_sequencer_inst (
    .clock_i             (clock_i),
    .rst_b_i             (rst_b_i),
    .bus_i               (bus),
    .rdata_o             (rdata),
    .calib_trigger_pin_i (pin),
    .sample_strobe_i     (strobe),
    .core_cal_done_i     (done),
    .offset_result_i     (ofs),
    .calib_status_pin_o  (stat),
    .core_map_o          (map),
    .spare_power_o       (spwr),
    .core_cal_run_o      (crun),
    .offset_cal_run_o    (orun),
    .fg_cal_run_o        (frun),
    .swap_pulse_o        (swp)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Sample boundaries arrive every other cycle, only while enabled.
  always @(posedge clock_i) begin
    strobe <= strobe_en & ~strobe;
  end

  task finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic sig(input int s);
    case (s)
      0: return frun;
      1: return spwr;
      2: return crun;
      default: return swp;
    endcase
  endfunction : sig

  // The count returned is the number of edges until the level is seen.
  task wait_until(input int s, input logic v, input int bound, output int cnt);
    for (cnt = 1; cnt <= bound; cnt++) begin
      @(posedge clock_i);
      #1;
      if (sig(s) === v) return;
    end
    failures++;
    $display("mismatch wait on signal %0d expected %0b seen timeout", s, v);
    finish_test();
  endtask : wait_until

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clock_i);
    bus.wr    <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clock_i);
    bus.rd   <= 1'b0;
    #1;
    check("rdata", rdata & m, e);
    @(posedge clock_i);
    #1;
    check("rdata after", rdata, 32'h0000_0000);
  endtask : rd

  task do_reset;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    #1;
  endtask : do_reset

  task pulse_done;
    @(posedge clock_i);
    done <= 1'b1;
    @(posedge clock_i);
    done <= 1'b0;
  endtask : pulse_done

  // Holding the swap back must also keep the spare's power state steady.
  task hold(input int cyc, input logic pw);
    repeat (cyc) begin
      @(posedge clock_i);
      #1;
      check("no swap", {31'h0, swp}, 32'h0000_0000);
      check("spare power", {31'h0, spwr}, {31'h0, pw});
    end
  endtask : hold

  initial begin
    failures = 0;
    comparisons = 0;
    bus = '0;
    pin = 1'b0;
    strobe = 1'b0;
    strobe_en = 1'b0;
    done = 1'b0;
    ofs = 8'h3C;
    rst_b_i = 1'b0;
    do_reset();
    check("reset outputs", {26'h0, spwr, stat, crun, orun, frun, swp}, 32'h0000_0020);
    check("reset map", 32'(map), 32'h0000_0021);
    rd(BGCS_REG_SLEEP, 32'h0000_FFFF, 32'h0000_0100);
    rd(BGCS_REG_WAKE, 32'h0000_FFFF, 32'h0000_0010);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(BGCS_REG_SLEEP, 32'h0000_0004);
    wr(BGCS_REG_WAKE, 32'h0000_0003);
    rd(BGCS_REG_SLEEP, 32'h0000_FFFF, 32'h0000_0004);
    wr(BGCS_REG_CTRL, AUTO ^ 32'h0000_0100);
    wr(BGCS_REG_CTRL, AUTO | 32'h0000_0004);
    wait_until(0, 1'b1, 10, n);
    check("fg offset", {31'h0, orun}, 32'h0000_0001);
    wait_until(0, 1'b0, 40, n);
    check("fg length", 32'(n), 32'h0000_0011);
    check("spare asleep", {31'h0, spwr}, 32'h0000_0000);
    wait_until(1, 1'b1, 20, n);
    check("sleep length", 32'(n), 32'h0000_0005);
    wait_until(2, 1'b1, 20, n);
    check("wake length", 32'(n), 32'h0000_0004);
    check("bg offset", {31'h0, orun}, 32'h0000_0001);
    pulse_done();
    hold(10, 1'b1);
    rd(BGCS_REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    strobe_en <= 1'b1;
    wait_until(3, 1'b1, 6, n);
    check("auto map", 32'(map), 32'h0000_0006);
    check("spare slept", {31'h0, spwr}, 32'h0000_0000);
    strobe_en <= 1'b0;
    @(posedge clock_i);
    ofs <= 8'h5A;
    do_reset();
    wr(BGCS_REG_STATUS, 32'h0000_0001);
    wr(BGCS_REG_SLEEP, 32'h0000_0004);
    wr(BGCS_REG_WAKE, 32'h0000_0003);
    wr(BGCS_REG_CTRL, MAN);
    @(posedge clock_i);
    pin <= 1'b1;
    wait_until(0, 1'b1, 10, n);
    wait_until(0, 1'b0, 40, n);
    rd(BGCS_REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    rd(BGCS_REG_TRIM, 32'hFFFF_FFFF, 32'h005A_5A5A);
    hold(20, 1'b0);
    @(posedge clock_i);
    pin <= 1'b0;
    wait_until(1, 1'b1, 10, n);
    wait_until(2, 1'b1, 20, n);
    strobe_en <= 1'b1;
    pulse_done();
    hold(12, 1'b1);
    check("halted pin", {31'h0, stat}, 32'h0000_0001);
    rd(BGCS_REG_STATUS, 32'h0000_0004, 32'h0000_0004);
    @(posedge clock_i);
    pin <= 1'b1;
    wait_until(3, 1'b1, 20, n);
    check("manual map", 32'(map), 32'h0000_0006);
    check("halted cleared", {31'h0, stat}, 32'h0000_0000);
    @(posedge clock_i);
    pin <= 1'b0;
    wait_until(2, 1'b1, 40, n);
    @(posedge clock_i);
    pin <= 1'b1;
    repeat (3) @(posedge clock_i);
    pulse_done();
    wait_until(3, 1'b1, 6, n);
    check("early map", 32'(map), 32'h0000_0018);
    finish_test();
  end
endmodule : bgcs_sequencer_test
`default_nettype wire
